// file: design/interval_calc.sv
// Interval calculator: fresh or stepped value, held at the minimum
`timescale 1ns/10ps
`default_nettype none
module interval_calc (
  // Selection
  input wire logic fresh_in,
  input wire logic adaptive_in,
  // Operands
  input wire logic [9:0] setting_in,
  input wire logic [9:0] avg_in,
  input wire logic [9:0] base_in,
  input wire logic [4:0] step_in,
  input wire logic [8:0] min_in,
  // Result
  output logic [9:0] value_out
);
  import tachy_pacing_pkg::*;

  logic [19:0] product;
  logic [19:0] quotient;
  logic [9:0] fresh_value;
  logic [9:0] stepped_value;
  logic [9:0] raw_value;

  // Percent of the four-cycle average, or a fixed value in ms
  always_comb begin
    product = 20'(setting_in) * 20'(avg_in);
    quotient = product / PCT_DIVISOR;
    fresh_value = adaptive_in ? quotient[9:0] : setting_in;
    stepped_value = (base_in > 10'(step_in)) ? base_in - 10'(step_in) : 10'h000;
    raw_value = fresh_in ? fresh_value : stepped_value;
    // Floor at the minimum; once there, further steps stay there
    value_out = (raw_value < 10'(min_in)) ? 10'(min_in) : raw_value;
  end
endmodule // interval_calc
`default_nettype wire

// file: design/tachy_pacing_pkg.sv
// Shared types and constants for the tachycardia pacing burst scheduler
package tachy_pacing_pkg;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TENTH_MS_NS = 100000;
  // Cycles per 0.1 ms; rounds down so the tick never runs slow
  localparam int TENTH_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
  localparam logic [13:0] TENTHS_PER_MS = 14'h00a;
  localparam logic [9:0] MS_PER_SEC = 10'h3e8;
  localparam logic [11:0] SEC_SATURATE = 12'hfff;

  // ******************************************************************
  // Limits and codes
  // ******************************************************************
  localparam logic [2:0] MAX_SHOCKS = 3'h5;
  localparam logic [4:0] MAX_ENERGY_CODE = 5'h12;
  localparam logic [19:0] PCT_DIVISOR = 20'h00064;
  localparam logic [1:0] ZONE_LOW = 2'h0;
  localparam logic [1:0] ZONE_MID = 2'h1;
  localparam logic [1:0] ZONE_HIGH = 2'h2;
  localparam logic [1:0] ZONE_NONE = 2'h3;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_COUPLE = 3'h1,
    ST_PACE = 3'h3,
    ST_WAIT = 3'h2,
    ST_SHOCK = 3'h6
  } sched_state_type;

  typedef enum logic [1:0] {
    KIND_BURST = 2'h0,
    KIND_RAMP = 2'h1,
    KIND_RAMP_SCAN = 2'h3,
    KIND_SCAN = 2'h2
  } scheme_kind_type;

  // One pacing scheme; bursts of zero means Off
  typedef struct packed {
    logic [4:0] bursts;
    logic [4:0] init_pulses;
    logic [2:0] pulse_inc;
    logic [4:0] max_pulses;
    logic [4:0] ramp_step;
    logic [4:0] scan_step;
    logic [4:0] delay_step;
    logic [8:0] min_interval;
    logic cl_adaptive;
    logic [9:0] cl_value;
    logic delay_adaptive;
    logic [9:0] delay_value;
  } scheme_cfg_type;

  // Per-zone settings; timeout in seconds, zero means Off
  typedef struct packed {
    scheme_cfg_type scheme;
    logic [11:0] timeout;
    logic [4:0] shock1_energy;
    logic [4:0] shock2_energy;
  } zone_cfg_type;

  // Common pacing output: width in 0.1 ms, amplitude code
  typedef struct packed {
    logic [4:0] width;
    logic [1:0] amplitude;
  } pace_cfg_type;

  // Global shock waveform selection
  typedef struct packed {
    logic biphasic;
    logic reversed;
  } shock_cfg_type;

endpackage

// file: design/tachy_pacing_therapy.sv
// Burst scheduler for tachycardia pacing with time-out and shock selection
// Overview of operation
// - Ramp shortens each paced interval inside a burst by the ramp step, 0-30 ms.
// - Later ramp bursts start the ramp from that burst's freshly computed cycle length.
// - Nonzero ramp step with zero scan and delay steps means a pure ramp.
// - Scan: each burst's cycle length is the previous minus the scan step.
// - With a nonzero scan or delay step, adaptive values are not recomputed after redetection.
// - Ramp and scan both nonzero: ramp bursts whose start length scans down.
// - Cycle length and delay never go below the minimum interval, 120-400 ms.
// - Minimum clamp is judged separately for delay and for cycle length.
// - Each scheme has its own burst count 1-30; Off disables it.
// - First burst holds the initial pulse count, 1-30.
// - Each later burst adds the pulse increment, 0-5.
// - Maximum pulse count caps bursts, only when the increment is nonzero.
// - One pulse width and amplitude serve all schemes and zones.
// - Each pacing zone has a time-out; lowest zone's is at least the middle's (not applied when the middle's is Off).
// - Time-out timer runs from first burst until shock or episode end, saturating past expiry.
// - After redetection, a reached time-out bars further bursts this episode.
// - Time-out never cuts short a burst in progress.
// - After time-out, shocks follow only once detection criteria hold again.
// - After any shock, no further pacing in the episode.
// - One elapsed timer is compared to both lower zones' time-outs.
// - At most five shocks; first two energies per zone, rest at maximum.
// - Shocks fire on a sensed event with one global waveform and polarity.
// - Adaptive values are a percent of the four-cycle average, else fixed ms.
// - Delay step shortens the first-pulse delay from burst to burst.
`timescale 1ns/10ps
`default_nettype none
module tachy_pacing_therapy #(
  parameter int TENTH_TICK_CYCLES = tachy_pacing_pkg::TENTH_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  // Detection side
  input wire logic REDETECT_IN,
  input wire logic [1:0] ZONE_IN,
  input wire logic SENSE_IN,
  input wire logic EPISODE_END_IN,
  input wire logic [9:0] AVG_CYCLE_IN,
  // Programmed settings
  input wire tachy_pacing_pkg::zone_cfg_type ZONE_CFG_IN [3],
  input wire tachy_pacing_pkg::pace_cfg_type PACE_CFG_IN,
  input wire tachy_pacing_pkg::shock_cfg_type SHOCK_CFG_IN,
  // Pacing output stage
  output logic PACE_OUT,
  output logic [1:0] PACE_AMP_OUT,
  output logic BURST_ACTIVE_OUT,
  output tachy_pacing_pkg::scheme_kind_type SCHEME_KIND_OUT,
  output logic [4:0] BURST_INDEX_OUT,
  // Shock output stage
  output logic SHOCK_PENDING_OUT,
  output logic SHOCK_FIRE_OUT,
  output logic [4:0] SHOCK_ENERGY_OUT,
  output tachy_pacing_pkg::shock_cfg_type SHOCK_WAVE_OUT,
  output logic [2:0] SHOCK_COUNT_OUT,
  // Status
  output logic [11:0] TIMER_SEC_OUT,
  output logic PACING_BARRED_OUT
);
  import tachy_pacing_pkg::*;

  // ******************************************************************
  // State
  // ******************************************************************
  sched_state_type state, next_state;
  scheme_cfg_type cfg, next_cfg;
  scheme_kind_type kind, next_kind;
  logic [1:0] zone, next_zone;
  logic [4:0] burst_idx, next_burst_idx;
  logic [5:0] pulses, next_pulses;
  logic [5:0] pulses_left, next_pulses_left;
  logic [9:0] cl_start, next_cl_start;
  logic [9:0] delay, next_delay;
  logic [9:0] cur_interval, next_cur_interval;
  logic [13:0] ivl_cnt, next_ivl_cnt;
  logic [4:0] width_cnt, next_width_cnt;
  logic [1:0] amp, next_amp;
  logic [2:0] shock_count, next_shock_count;
  logic shocked, next_shocked;
  logic [4:0] energy, next_energy;
  logic fire, next_fire;
  logic start_q, next_start_q;
  logic pace_on, next_pace_on;
  logic [11:0] tenth_cnt, next_tenth_cnt;
  logic [3:0] ms_sub, next_ms_sub;
  logic [9:0] ms_cnt, next_ms_cnt;
  logic [11:0] sec_cnt, next_sec_cnt;
  logic timer_run, next_timer_run;
  logic timer_started, next_timer_started;

  // Decision helpers
  logic tenth;
  logic [1:0] zsel;
  zone_cfg_type zc;
  logic new_zone;
  logic [4:0] idx;
  logic fresh;
  logic [11:0] eff_timeout;
  logic timed_out;
  logic pace_ok;
  logic launch;
  logic launch_first;
  logic timer_go;
  logic [5:0] grown;
  logic [9:0] cl_calc_value;
  logic [9:0] delay_calc_value;
  logic [9:0] ramp_value;

  // ******************************************************************
  // Interval arithmetic
  // ******************************************************************
  // Cycle length and delay have their own clamps so each saturates alone
  interval_calc cl_calc (
    .fresh_in(fresh),
    .adaptive_in(zc.scheme.cl_adaptive),
    .setting_in(zc.scheme.cl_value),
    .avg_in(AVG_CYCLE_IN),
    .base_in(cl_start),
    .step_in(zc.scheme.scan_step),
    .min_in(zc.scheme.min_interval),
    .value_out(cl_calc_value)
  );

  interval_calc delay_calc (
    .fresh_in(fresh),
    .adaptive_in(zc.scheme.delay_adaptive),
    .setting_in(zc.scheme.delay_value),
    .avg_in(AVG_CYCLE_IN),
    .base_in(delay),
    .step_in(zc.scheme.delay_step),
    .min_in(zc.scheme.min_interval),
    .value_out(delay_calc_value)
  );

  // Ramp runs on the latched scheme, never fresh
  interval_calc ramp_calc (
    .fresh_in(1'b0),
    .adaptive_in(1'b0),
    .setting_in(10'h000),
    .avg_in(10'h000),
    .base_in(cur_interval),
    .step_in(cfg.ramp_step),
    .min_in(cfg.min_interval),
    .value_out(ramp_value)
  );

  // ******************************************************************
  // Decision terms
  // ******************************************************************
  always_comb begin
    tenth = (tenth_cnt == 12'(TENTH_TICK_CYCLES - 1));
    zsel = (ZONE_IN > ZONE_HIGH) ? ZONE_HIGH : ZONE_IN;
    zc = ZONE_CFG_IN[zsel];
    new_zone = (zsel != zone);
    idx = new_zone ? 5'h00 : burst_idx;
    // Fresh values only for a first burst or when no scan or delay step is set
    fresh = (idx == 5'h00) || ((zc.scheme.scan_step == 5'h00) &&
            (zc.scheme.delay_step == 5'h00));
    // Lowest zone never times out before the middle zone unless the middle zone's time-out is Off
    eff_timeout = zc.timeout;
    if ((zsel == ZONE_LOW) && (zc.timeout != 12'h000) &&
        (zc.timeout < ZONE_CFG_IN[ZONE_MID].timeout)) begin
      eff_timeout = ZONE_CFG_IN[ZONE_MID].timeout;
    end
    // One shared timer against each zone's own limit
    timed_out = (eff_timeout != 12'h000) && (sec_cnt >= eff_timeout);
    // Burst count Off or used up, shocked, or timed out: no pacing
    pace_ok = (zsel != ZONE_HIGH) && !shocked && !timed_out &&
              (zc.scheme.bursts != 5'h00) && (idx < zc.scheme.bursts);
    // Pulse count grows by the increment, capped only if it is nonzero
    grown = pulses + 6'(zc.scheme.pulse_inc);
    if (grown > 6'(zc.scheme.max_pulses)) begin
      grown = 6'(zc.scheme.max_pulses);
    end
    launch_first = (state == ST_COUPLE) && tenth && (ivl_cnt <= 14'h0001);
    launch = launch_first || ((state == ST_PACE) && tenth &&
             (pulses_left != 6'h00) && (ivl_cnt <= 14'h0001));
  end

  // ******************************************************************
  // Therapy sequencing
  // ******************************************************************
  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_kind = kind;
    next_zone = zone;
    next_burst_idx = burst_idx;
    next_pulses = pulses;
    next_pulses_left = pulses_left;
    next_cl_start = cl_start;
    next_delay = delay;
    next_cur_interval = cur_interval;
    next_ivl_cnt = ivl_cnt;
    next_width_cnt = width_cnt;
    next_amp = amp;
    next_shock_count = shock_count;
    next_shocked = shocked;
    next_energy = energy;
    next_fire = 1'b0;
    next_start_q = 1'b0;
    timer_go = 1'b0;
    case (state)
      ST_IDLE, ST_WAIT: begin
        // Therapy moves only on a fresh redetection
        if (REDETECT_IN && pace_ok) begin
          next_state = ST_COUPLE;
          next_zone = zsel;
          next_cfg = zc.scheme;
          next_burst_idx = idx + 5'h01;
          next_start_q = 1'b1;
          next_cl_start = cl_calc_value;
          next_delay = delay_calc_value;
          next_ivl_cnt = 14'(delay_calc_value) * TENTHS_PER_MS;
          if (idx == 5'h00 || zc.scheme.pulse_inc == 3'h0) begin
            next_pulses = 6'(zc.scheme.init_pulses);
          end else begin
            next_pulses = grown;
          end
          // Scheme class from the three steps
          if (zc.scheme.ramp_step != 5'h00) begin
            next_kind = (zc.scheme.scan_step != 5'h00) ? KIND_RAMP_SCAN :
                        ((zc.scheme.delay_step == 5'h00) ? KIND_RAMP : KIND_SCAN);
          end else begin
            next_kind = (zc.scheme.scan_step != 5'h00 || zc.scheme.delay_step != 5'h00) ?
                        KIND_SCAN : KIND_BURST;
          end
        end else if (REDETECT_IN && shock_count < MAX_SHOCKS) begin
          // Skip remaining pacing and go to this zone's shocks
          next_state = ST_SHOCK;
          next_zone = zsel;
          if (shock_count == 3'h0) begin
            next_energy = zc.shock1_energy;
          end else if (shock_count == 3'h1) begin
            next_energy = zc.shock2_energy;
          end else begin
            next_energy = MAX_ENERGY_CODE;
          end
        end
      end
      ST_COUPLE: begin
        if (tenth && !launch) begin
          next_ivl_cnt = ivl_cnt - 14'h0001;
        end
      end
      ST_PACE: begin
        // Burst runs to its last pulse unless the episode ends; no time-out check here
        if (tenth) begin
          next_ivl_cnt = ivl_cnt - 14'h0001;
          if (width_cnt != 5'h00) begin
            next_width_cnt = width_cnt - 5'h01;
          end
        end
        if (pulses_left == 6'h00 && width_cnt == 5'h00) begin
          next_state = ST_WAIT;
        end
      end
      ST_SHOCK: begin
        // Fire on the sensed event with the global waveform
        if (SENSE_IN) begin
          next_fire = 1'b1;
          next_shock_count = shock_count + 3'h1;
          next_shocked = 1'b1;
          next_state = ST_WAIT;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Pulse launch: first pulse after coupling, later ones ramp down
    if (launch) begin
      next_state = ST_PACE;
      next_cur_interval = launch_first ? cl_start : ramp_value;
      next_ivl_cnt = 14'(next_cur_interval) * TENTHS_PER_MS;
      next_width_cnt = PACE_CFG_IN.width;
      next_amp = PACE_CFG_IN.amplitude;
      next_pulses_left = (launch_first ? pulses : pulses_left) - 6'h01;
      timer_go = launch_first;
    end
    // Episode end wins and clears state, zone, burst index, pulses left, width and shocks
    if (EPISODE_END_IN) begin
      next_state = ST_IDLE;
      next_zone = ZONE_NONE;
      next_burst_idx = 5'h00;
      next_pulses_left = 6'h00;
      next_width_cnt = 5'h00;
      // A shock firing on this same edge is still counted, so its set wins
      next_shock_count = {2'b00, next_fire};
      next_shocked = next_fire;
    end
    next_pace_on = (next_width_cnt != 5'h00);
  end

  // Registers of the sequencer
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      state <= ST_IDLE;
      cfg <= '0;
      kind <= KIND_BURST;
      zone <= ZONE_NONE;
      burst_idx <= 5'h00;
      pulses <= 6'h00;
      pulses_left <= 6'h00;
      cl_start <= 10'h000;
      delay <= 10'h000;
      cur_interval <= 10'h000;
      ivl_cnt <= 14'h0000;
      width_cnt <= 5'h00;
      amp <= 2'h0;
      shock_count <= 3'h0;
      shocked <= 1'b0;
      energy <= 5'h00;
      fire <= 1'b0;
      start_q <= 1'b0;
      pace_on <= 1'b0;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      kind <= next_kind;
      zone <= next_zone;
      burst_idx <= next_burst_idx;
      pulses <= next_pulses;
      pulses_left <= next_pulses_left;
      cl_start <= next_cl_start;
      delay <= next_delay;
      cur_interval <= next_cur_interval;
      ivl_cnt <= next_ivl_cnt;
      width_cnt <= next_width_cnt;
      amp <= next_amp;
      shock_count <= next_shock_count;
      shocked <= next_shocked;
      energy <= next_energy;
      fire <= next_fire;
      start_q <= next_start_q;
      pace_on <= next_pace_on;
    end
  end

  // ******************************************************************
  // Time base and time-out timer
  // ******************************************************************
  // Starts at the first burst; stops on shock or episode end
  always_comb begin
    next_tenth_cnt = tenth ? 12'h000 : tenth_cnt + 12'h001;
    next_ms_sub = ms_sub;
    next_ms_cnt = ms_cnt;
    next_sec_cnt = sec_cnt;
    next_timer_run = timer_run;
    next_timer_started = timer_started;
    if (timer_go && !timer_started && !shocked) begin
      next_timer_run = 1'b1;
      next_timer_started = 1'b1;
    end
    if (timer_run && tenth) begin
      next_ms_sub = (ms_sub == 4'(TENTHS_PER_MS - 14'h0001)) ? 4'h0 : ms_sub + 4'h1;
      if (ms_sub == 4'(TENTHS_PER_MS - 14'h0001)) begin
        next_ms_cnt = (ms_cnt == MS_PER_SEC - 10'h001) ? 10'h000 : ms_cnt + 10'h001;
        // Saturate rather than wrap so a reached time-out stays reached
        if (ms_cnt == MS_PER_SEC - 10'h001 && sec_cnt != SEC_SATURATE) begin
          next_sec_cnt = sec_cnt + 12'h001;
        end
      end
    end
    if (next_fire) begin
      next_timer_run = 1'b0;
    end
    if (EPISODE_END_IN) begin
      next_timer_run = 1'b0;
      next_timer_started = 1'b0;
      next_ms_sub = 4'h0;
      next_ms_cnt = 10'h000;
      next_sec_cnt = 12'h000;
    end
  end

  // Registers of the time base
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      tenth_cnt <= 12'h000;
      ms_sub <= 4'h0;
      ms_cnt <= 10'h000;
      sec_cnt <= 12'h000;
      timer_run <= 1'b0;
      timer_started <= 1'b0;
    end else begin
      tenth_cnt <= next_tenth_cnt;
      ms_sub <= next_ms_sub;
      ms_cnt <= next_ms_cnt;
      sec_cnt <= next_sec_cnt;
      timer_run <= next_timer_run;
      timer_started <= next_timer_started;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign PACE_OUT = pace_on;
  assign PACE_AMP_OUT = amp;
  assign BURST_ACTIVE_OUT = (state == ST_COUPLE) || (state == ST_PACE);
  assign SCHEME_KIND_OUT = kind;
  assign BURST_INDEX_OUT = burst_idx;
  assign SHOCK_PENDING_OUT = (state == ST_SHOCK);
  assign SHOCK_FIRE_OUT = fire;
  assign SHOCK_ENERGY_OUT = energy;
  assign SHOCK_WAVE_OUT = SHOCK_CFG_IN;
  assign SHOCK_COUNT_OUT = shock_count;
  assign TIMER_SEC_OUT = sec_cnt;
  assign PACING_BARRED_OUT = shocked;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);

  ramp_within_burst_a: assert property (
    launch && !launch_first |=> (cur_interval + 10'(cfg.ramp_step) == $past(cur_interval)) ||
      (cur_interval == 10'(cfg.min_interval)))
    else $error("ramp interval not shortened by the step");
  scan_between_a: assert property (
    start_q && burst_idx > 5'h01 && cfg.scan_step != 5'h00 |->
      (cl_start + 10'(cfg.scan_step) == $past(cl_start)) || (cl_start == 10'(cfg.min_interval)))
    else $error("scan cycle length not stepped");
  min_clamp_a: assert property (
    start_q |-> cl_start >= 10'(cfg.min_interval) && delay >= 10'(cfg.min_interval))
    else $error("interval below minimum");
  first_pulses_a: assert property (
    start_q && burst_idx == 5'h01 |-> pulses == 6'(cfg.init_pulses))
    else $error("first burst pulse count wrong");
  timeout_block_a: assert property (
    REDETECT_IN && (state == ST_IDLE || state == ST_WAIT) && timed_out && !EPISODE_END_IN
      |=> state != ST_COUPLE)
    else $error("burst started after time-out");
  burst_complete_a: assert property (
    state == ST_PACE && !EPISODE_END_IN |=> state == ST_PACE || state == ST_WAIT)
    else $error("burst cut short");
  shock_cause_a: assert property (
    $rose(state == ST_SHOCK) |-> $past(REDETECT_IN))
    else $error("shock without redetection");
  no_pace_shock_a: assert property (
    shocked |-> !launch_first)
    else $error("pacing after shock");
  timer_stop_a: assert property (
    SHOCK_FIRE_OUT |-> !timer_run ##1 !timer_run)
    else $error("timer running after shock");
  shock_energy_a: assert property (
    SHOCK_FIRE_OUT && shock_count > 3'h2 |-> SHOCK_ENERGY_OUT == MAX_ENERGY_CODE &&
      shock_count <= MAX_SHOCKS)
    else $error("later shock not at maximum");
  shock_sync_a: assert property (
    SHOCK_FIRE_OUT |-> $past(SENSE_IN) && $past(state == ST_SHOCK))
    else $error("shock not tied to sensed event");

  burst_done_c: cover property (state == ST_PACE ##1 state == ST_WAIT);
  ramp_scan_c: cover property (start_q && kind == KIND_RAMP_SCAN && burst_idx == 5'h02);
  timeout_shock_c: cover property (REDETECT_IN && timed_out && state == ST_WAIT);
  fifth_shock_c: cover property (SHOCK_FIRE_OUT && shock_count == MAX_SHOCKS);
endmodule // tachy_pacing_therapy
`default_nettype wire

// file: tb/tachy_far_side.sv
// Far-side model: beat sensing for an armed shock, pace pulse counter
`timescale 1ns/10ps
`default_nettype none
module tachy_far_side (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Output stage
  input wire logic pace_in,
  input wire logic pending_in,
  // Sensing
  output logic sense_out,
  output logic [7:0] pulses_out
);
  logic last_pace;
  logic [3:0] wait_cnt;
  // A beat arrives some cycles after arming, so the shock is never instant
  always_ff @(posedge clk_in) begin
    last_pace <= pace_in;
    sense_out <= 1'b0;
    if (rst_in) begin
      pulses_out <= 8'h00;
      wait_cnt <= 4'h0;
    end else begin
      if (pace_in && !last_pace) begin
        pulses_out <= pulses_out + 8'h01;
      end
      wait_cnt <= (pending_in && !sense_out) ? wait_cnt + 4'h1 : 4'h0;
      if (wait_cnt == 4'h7) begin
        sense_out <= 1'b1;
      end
    end
  end
endmodule // tachy_far_side
`default_nettype wire

// file: tb/test_tachy_pacing_therapy.sv
// Self-checking bench for the pacing burst scheduler
`timescale 1ns/10ps
`default_nettype none
module test_tachy_pacing_therapy;
  import tachy_pacing_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic redet = 1'b0;
  logic [1:0] zone = 2'h0;
  logic ep_end = 1'b0;
  logic sense, pace, active, pend, fire, barred;
  zone_cfg_type cfg [3];
  pace_cfg_type pcfg = '{5'h05, 2'h2};
  shock_cfg_type scfg, wave;
  logic [1:0] amp;
  scheme_kind_type kind;
  logic [4:0] idx, energy;
  logic [2:0] count;
  logic [11:0] timer;
  logic [7:0] pulses;
  logic [31:0] seed = 32'hc2b7;
  int n_errors = 0;
  int checked = 0;
  int fires = 0;
  int shots = 0;
  // One tick per cycle keeps a 120 ms interval at 1200 cycles
  tachy_pacing_therapy #(.TENTH_TICK_CYCLES(1)) DUT (.SYS_CLK_IN(clk), .RESET_IN(rst),
    .REDETECT_IN(redet), .ZONE_IN(zone), .SENSE_IN(sense), .EPISODE_END_IN(ep_end),
    .AVG_CYCLE_IN(10'h190), .ZONE_CFG_IN(cfg), .PACE_CFG_IN(pcfg), .SHOCK_CFG_IN(scfg),
    .PACE_OUT(pace), .PACE_AMP_OUT(amp), .BURST_ACTIVE_OUT(active), .SCHEME_KIND_OUT(kind),
    .BURST_INDEX_OUT(idx), .SHOCK_PENDING_OUT(pend), .SHOCK_FIRE_OUT(fire),
    .SHOCK_ENERGY_OUT(energy), .SHOCK_WAVE_OUT(wave), .SHOCK_COUNT_OUT(count),
    .TIMER_SEC_OUT(timer), .PACING_BARRED_OUT(barred));
  tachy_far_side far (.clk_in(clk), .rst_in(rst), .pace_in(pace), .pending_in(pend),
    .sense_out(sense), .pulses_out(pulses));
  // Clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Cycles from start to end of a burst: clamped delay, clamped ramped intervals, width
  function automatic int span(input int d, input int c, input int r, input int p, input int m);
    int s;
    s = (d < m) ? m : d;
    for (int k = 0; k < p - 1; k++) begin
      s += (c - k * r < m) ? m : c - k * r;
    end
    return 10 * s + int'(pcfg.width);
  endfunction
  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulse a request, then sample one edge after it is taken
  task automatic step(input logic [1:0] z);
    @(posedge clk);
    redet <= 1'b1;
    zone <= z;
    @(posedge clk);
    redet <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for the scheduler to go quiet
  // Sampled after each edge settles; counts cycles and shock pulses seen
  task automatic wait_idle(output int n);
    for (n = 0; n < 20000 && (active !== 1'b0 || pend !== 1'b0); n++) begin
      @(posedge clk);
      #1;
      if (fire === 1'b1) begin
        fires++;
      end
    end
    if (n == 20000) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic burst(input logic [1:0] z, input logic [7:0] n, input logic [4:0] b,
      input logic [1:0] k, input int len);
    logic [7:0] start;
    int got;
    start = pulses;
    step(z);
    check(active, 1'b1);
    check({idx, kind}, {b, k});
    wait_idle(got);
    check(24'(got), 24'(len));
    check(pulses - start, n);
    check(amp, pcfg.amplitude);
  endtask
  task automatic shock(input logic [1:0] z, input logic [4:0] e, input logic [2:0] c);
    int got;
    shots++;
    step(z);
    check(pend, 1'b1);
    check(energy, e);
    wait_idle(got);
    check({count, barred}, {c, 1'b1});
    check(24'(fires), 24'(shots));
  endtask
  initial begin
    // Random energy codes and waveform; zone 0 at fixed 120 ms timing
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      cfg[k] = '0;
      cfg[k].shock1_energy = 5'(seed[7:0] % 19);
      cfg[k].shock2_energy = 5'(seed[15:8] % 19);
    end
    scfg = seed[17:16];
    cfg[0].scheme.bursts = 5'h02;
    cfg[0].scheme.init_pulses = 5'h03;
    cfg[0].scheme.pulse_inc = 3'h2;
    cfg[0].scheme.max_pulses = 5'h1e;
    cfg[0].scheme.min_interval = 9'h078;
    cfg[0].scheme.cl_value = 10'h078;
    cfg[0].scheme.delay_value = 10'h078;
    // Ramp/scan scheme whose delay starts below the minimum
    cfg[1].scheme.bursts = 5'h02;
    cfg[1].scheme.init_pulses = 5'h03;
    cfg[1].scheme.ramp_step = 5'h0a;
    cfg[1].scheme.scan_step = 5'h14;
    cfg[1].scheme.min_interval = 9'h0b4;
    cfg[1].scheme.cl_value = 10'h0c8;
    cfg[1].scheme.delay_value = 10'h096;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({active, pend, count, idx, timer}, 24'h000000);
    check({pace, amp, kind, fire, barred, energy}, 24'h000000);
    burst(2'h0, 8'h03, 5'h01, KIND_BURST, span(120, 120, 0, 3, 120));
    burst(2'h0, 8'h05, 5'h02, KIND_BURST, span(120, 120, 0, 5, 120));
    shock(2'h0, cfg[0].shock1_energy, 3'h1);
    shock(2'h0, cfg[0].shock2_energy, 3'h2);
    for (int k = 3; k < 6; k++) begin
      shock(2'h2, MAX_ENERGY_CODE, 3'(k));
    end
    step(2'h2);
    check(pend, 1'b0);
    check(wave, scfg);
    @(posedge clk);
    ep_end <= 1'b1;
    @(posedge clk);
    ep_end <= 1'b0;
    @(posedge clk);
    #1;
    check({count, barred, timer}, 24'h000000);
    burst(2'h1, 8'h03, 5'h01, KIND_RAMP_SCAN, span(150, 200, 10, 3, 180));
    burst(2'h1, 8'h03, 5'h02, KIND_RAMP_SCAN, span(150, 200 - 20, 10, 3, 180));
    shock(2'h1, cfg[1].shock1_energy, 3'h1);
    final_report();
  end
endmodule // test_tachy_pacing_therapy
`default_nettype wire
